// ===== hdl/e3tx_map.vh
// Register offsets, field positions and reset values of the E3 transmit overhead block.
// Included by the register and overhead design files and the bench; definitions only.
`ifndef E3TX_MAP_VH
`define E3TX_MAP_VH

// ---------------------------------------------
// Register word indices and byte addresses (Avalon word aligned)
// ---------------------------------------------
`define E3TX_IDX_CONTROL 8'h18
`define E3TX_IDX_ERRINS 8'h1A
`define E3TX_ADDR_CONTROL 10'h060
`define E3TX_ADDR_ERRINS 10'h068
`define E3TX_ADDR_W 10

// ---------------------------------------------
// Control register fields
// ---------------------------------------------
`define E3TX_CTL_ALARM 0
`define E3TX_CTL_FGDIS 1
`define E3TX_CTL_ASEL_LO 2
`define E3TX_CTL_NSEL_LO 8
`define E3TX_CTL_MASK 16'h030F
`define E3TX_CTL_RESET 16'h0000

// ---------------------------------------------
// Error insertion register fields
// ---------------------------------------------
`define E3TX_EI_MODE 0
`define E3TX_EI_SWINS 1
`define E3TX_EI_EN 2
`define E3TX_EI_KIND_LO 3
`define E3TX_EI_MASK 16'h001F
`define E3TX_EI_RESET 16'h0000

// ---------------------------------------------
// Source select codes
// ---------------------------------------------
`define E3TX_N_ONE 2'h0
`define E3TX_N_HDLC 2'h1
`define E3TX_N_FEAC 2'h2
`define E3TX_N_ZERO 2'h3
`define E3TX_A_AUTO 2'h0
`define E3TX_A_FEAC 2'h1
`define E3TX_A_ZERO 2'h2
`define E3TX_A_ONE 2'h3

// ---------------------------------------------
// Frame layout: 10-bit alignment word, A and N bits
// ---------------------------------------------
`define E3TX_FAS_LEN 4'hC
`define E3TX_FAS_WORD 10'h3D0
`define E3TX_POS_A 4'hA
`define E3TX_POS_N 4'hB
`define E3TX_MULTI_FRAMES 3'h4

`endif

// ===== hdl/e3tx_sync.v
// Two-flop synchroniser for one level arriving from outside the core_clk domain.
// Assumes core_clk and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module e3tx_sync (
  input wire core_clk,
  input wire rst_n,
  input wire din,
  output wire dout
);
  reg meta_r;
  reg sync_r;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule

`default_nettype wire

// ===== hdl/e3tx_regs.v
// Avalon-MM slave holding the two control registers of the transmit block.
// Assumes a master that holds its request until waitrequest is low; one wait state per access.
`timescale 1ns/1ps
`default_nettype none
`include "e3tx_map.vh"

module e3tx_regs (
  input wire core_clk,
  input wire rst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [15:0] e3_tx_control_r,
  output reg [15:0] e3_tx_error_insert_r
);
  reg ack_r;
  wire req;
  wire [15:0] wmask;

  assign req = avs_read | avs_write;
  // Low only in the second cycle of a request, so every access takes two edges
  assign avs_waitrequest = req & ~ack_r;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h00000000;
      e3_tx_control_r <= `E3TX_CTL_RESET;
      e3_tx_error_insert_r <= `E3TX_EI_RESET;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r & avs_read) begin
        case (avs_address)
          `E3TX_ADDR_CONTROL: avs_readdata <= {16'h0000, e3_tx_control_r};
          `E3TX_ADDR_ERRINS: avs_readdata <= {16'h0000, e3_tx_error_insert_r};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (req & ~ack_r & avs_write) begin
        // Reserved bits stay zero
        if (avs_address == `E3TX_ADDR_CONTROL) begin
          e3_tx_control_r <= ((e3_tx_control_r & ~wmask) | (avs_writedata[15:0] & wmask))
                             & `E3TX_CTL_MASK;
        end
        if (avs_address == `E3TX_ADDR_ERRINS) begin
          e3_tx_error_insert_r <= ((e3_tx_error_insert_r & ~wmask)
                                  | (avs_writedata[15:0] & wmask)) & `E3TX_EI_MASK;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ===== hdl/e3tx_overhead.v
// E3 transmit overhead fill, frame generation control, alarm and framing error insertion.
// Assumes a bit-serial payload on core_clk with a frame-start strobe from the mapper; overhead
// positions are counted here from that strobe; the manual insert pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "e3tx_map.vh"

// How it works
// - The N bit is sent as 1, the HDLC bit, the FEAC bit or 0 for select codes 00 to 11.
// - The A bit is automatic alarm, the FEAC bit, 0 or 1 for select codes 00 to 11.
// - With both selecting FEAC, both bits carry the one FEAC stream, one bit per frame each.
// - With generation enabled, internal overhead overwrites the payload overhead positions.
// - With generation disabled, incoming overhead passes to error insertion unchanged.
// - The alarm bit forces the entire outgoing stream to all ones.
// - The error kind picks bit or word error in one frame or four consecutive frames.
// - No framing error is injected by any trigger unless insertion is enabled.
// - In software mode a rising edge of the single-insert bit injects one error.
// - Several toggles between two insertion opportunities still give only one error.
// - Triggers come from the software bit in mode 0 and the external input in mode 1.
// - Switching mode while a trigger source is high may inject an error.
// - In automatic mode the A bit is one while enabled receive alarms are present.
module e3tx_overhead (
  input wire core_clk,
  input wire rst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire pay_valid,
  input wire pay_data,
  input wire pay_frame_start,
  input wire hdlc_bit,
  input wire feac_bit,
  input wire rx_los,
  input wire rx_oof,
  input wire rx_ais,
  input wire rx_lof,
  input wire rai_los_disable,
  input wire rai_oof_disable,
  input wire rai_ais_disable,
  input wire rai_lof_enable,
  input wire external_error_insert_input,
  output reg line_valid,
  output reg line_data,
  output wire hdlc_bit_take,
  output wire feac_bit_take
);
  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  wire [15:0] ctl;
  wire [15:0] eir;

  e3tx_regs u_regs (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .e3_tx_control_r(ctl),
    .e3_tx_error_insert_r(eir)
  );

  wire transmit_alarm_all_ones = ctl[`E3TX_CTL_ALARM];
  wire frame_generation_disable = ctl[`E3TX_CTL_FGDIS];
  wire [1:0] a_bit_source_select = ctl[`E3TX_CTL_ASEL_LO +: 2];
  wire [1:0] n_bit_source_select = ctl[`E3TX_CTL_NSEL_LO +: 2];
  wire manual_insert_mode_select = eir[`E3TX_EI_MODE];
  wire software_single_insert = eir[`E3TX_EI_SWINS];
  wire framing_error_insert_enable = eir[`E3TX_EI_EN];
  wire [1:0] framing_error_kind = eir[`E3TX_EI_KIND_LO +: 2];

  // ---------------------------------------------
  // Asynchronous inputs
  // ---------------------------------------------
  wire ext_sync;
  wire los_s;
  wire oof_s;
  wire ais_s;
  wire lof_s;

  e3tx_sync u_sync_ext (.core_clk(core_clk), .rst_n(rst_n),
    .din(external_error_insert_input), .dout(ext_sync));
  e3tx_sync u_sync_los (.core_clk(core_clk), .rst_n(rst_n), .din(rx_los), .dout(los_s));
  e3tx_sync u_sync_oof (.core_clk(core_clk), .rst_n(rst_n), .din(rx_oof), .dout(oof_s));
  e3tx_sync u_sync_ais (.core_clk(core_clk), .rst_n(rst_n), .din(rx_ais), .dout(ais_s));
  e3tx_sync u_sync_lof (.core_clk(core_clk), .rst_n(rst_n), .din(rx_lof), .dout(lof_s));

  // ---------------------------------------------
  // Frame position
  // ---------------------------------------------
  // Counts overhead bit positions from the frame-start strobe; stops at the end of overhead
  reg [3:0] pos_r;
  wire in_oh = pay_valid & (pay_frame_start | (pos_r < `E3TX_FAS_LEN));
  wire [3:0] pos = pay_frame_start ? 4'h0 : pos_r;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= `E3TX_FAS_LEN;
    end else if (pay_valid) begin
      if (pay_frame_start) begin
        pos_r <= 4'h1;
      end else if (pos_r < `E3TX_FAS_LEN) begin
        pos_r <= pos_r + 4'h1;
      end
    end
  end

  // ---------------------------------------------
  // Overhead bit sources
  // ---------------------------------------------
  // The FEAC bit is held for a whole frame so N and A share one stream bit per frame
  reg feac_hold_r;
  wire n_is_feac = (n_bit_source_select == `E3TX_N_FEAC);
  wire a_is_feac = (a_bit_source_select == `E3TX_A_FEAC);
  assign feac_bit_take = pay_valid & pay_frame_start & (n_is_feac | a_is_feac);
  assign hdlc_bit_take = pay_valid & in_oh & (pos == `E3TX_POS_N)
                         & (n_bit_source_select == `E3TX_N_HDLC);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      feac_hold_r <= 1'b0;
    end else if (feac_bit_take) begin
      feac_hold_r <= feac_bit;
    end
  end

  wire feac_now = pay_frame_start ? feac_bit : feac_hold_r;
  wire rai_auto = (los_s & ~rai_los_disable) | (oof_s & ~rai_oof_disable)
                  | (ais_s & ~rai_ais_disable) | (lof_s & rai_lof_enable);

  reg n_bit;
  reg a_bit;

  always @* begin
    case (n_bit_source_select)
      `E3TX_N_ONE: n_bit = 1'b1;
      `E3TX_N_HDLC: n_bit = hdlc_bit;
      `E3TX_N_FEAC: n_bit = feac_now;
      default: n_bit = 1'b0;
    endcase
    case (a_bit_source_select)
      `E3TX_A_AUTO: a_bit = rai_auto;
      `E3TX_A_FEAC: a_bit = feac_now;
      `E3TX_A_ZERO: a_bit = 1'b0;
      default: a_bit = 1'b1;
    endcase
  end

  // Sent first bit first: bit 9 leaves at position 0
  localparam [9:0] fas_pattern = `E3TX_FAS_WORD;

  function gen_bit;
    input [3:0] p;
    input nb;
    input ab;
    begin
      if (p == `E3TX_POS_A) begin
        gen_bit = ab;
      end else if (p == `E3TX_POS_N) begin
        gen_bit = nb;
      end else begin
        gen_bit = fas_pattern[4'h9 - p];
      end
    end
  endfunction

  wire framed = (in_oh & ~frame_generation_disable) ? gen_bit(pos, n_bit, a_bit)
                : pay_data;

  // ---------------------------------------------
  // Error trigger
  // ---------------------------------------------
  // Mode switch with a high source looks like an edge; software must lower both first
  reg trig_d_r;
  reg pending_r;
  wire trig_src = manual_insert_mode_select ? ext_sync : software_single_insert;
  wire trig_edge = trig_src & ~trig_d_r;

  // ---------------------------------------------
  // Error insertion over one or four frames
  // ---------------------------------------------
  reg [2:0] frames_left_r;
  reg word_r;
  wire start_err = pay_valid & pay_frame_start & pending_r & framing_error_insert_enable;
  // A running four-frame error also covers bit 0 of each later frame it spans
  wire active = pay_frame_start ? (start_err | (frames_left_r > 3'h1))
                : (frames_left_r != 3'h0);
  wire word_mode = start_err ? framing_error_kind[0] : word_r;
  wire flip = active & in_oh & (pos < 4'hA) & (word_mode | (pos == 4'h0));

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_r <= 1'b0;
      pending_r <= 1'b0;
      frames_left_r <= 3'h0;
      word_r <= 1'b0;
    end else begin
      trig_d_r <= trig_src;
      // Set wins over the consume; extra edges before the opportunity merge into one
      if (trig_edge & framing_error_insert_enable) begin
        pending_r <= 1'b1;
      end else if (start_err | ~framing_error_insert_enable) begin
        pending_r <= 1'b0;
      end
      if (pay_valid & pay_frame_start) begin
        if (start_err) begin
          frames_left_r <= framing_error_kind[1] ? `E3TX_MULTI_FRAMES : 3'h1;
          word_r <= framing_error_kind[0];
        end else if (frames_left_r != 3'h0) begin
          frames_left_r <= frames_left_r - 3'h1;
        end
      end
      if (~framing_error_insert_enable) begin
        frames_left_r <= 3'h0;
      end
    end
  end

  // ---------------------------------------------
  // Line output
  // ---------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_valid <= 1'b0;
      line_data <= 1'b0;
    end else begin
      line_valid <= pay_valid;
      if (pay_valid) begin
        line_data <= transmit_alarm_all_ones ? 1'b1 : (framed ^ flip);
      end
    end
  end
endmodule

`default_nettype wire

// ===== dv/e3tx_checker.sv
// Concurrent checks on the E3 transmit overhead block.
// Sees only top-level ports; register shadows assume full 16-bit writes.
`timescale 1ns/1ps
`default_nettype none
`include "e3tx_map.vh"
module e3tx_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pay_valid,
  input wire logic pay_data,
  input wire logic pay_frame_start,
  input wire logic hdlc_bit,
  input wire logic line_data,
  input wire logic hdlc_bit_take,
  input wire logic feac_bit_take
);
  localparam logic [9:0] fas_word = 10'h02F;
  logic [15:0] ctl_r;
  logic [15:0] ei_r;
  logic [3:0] pos_r;
  wire [3:0] pos = pay_frame_start ? 4'h0 : pos_r;
  wire acc = !avs_waitrequest;
  wire gen = pay_valid && !ctl_r[1] && !ctl_r[0];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= 16'h0000;
      ei_r <= 16'h0000;
      pos_r <= 4'h0;
    end else begin
      if (pay_valid)
        pos_r <= pos + 4'h1;
      if (avs_write && acc && avs_address == `E3TX_ADDR_CONTROL)
        ctl_r <= avs_writedata[15:0] & `E3TX_CTL_MASK;
      if (avs_write && acc && avs_address == `E3TX_ADDR_ERRINS)
        ei_r <= avs_writedata[15:0] & `E3TX_EI_MASK;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_req_new;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_n_pos;
    gen && pos == 4'hB;
  endsequence
  sequence s_a_pos;
    gen && pos == 4'hA;
  endsequence
  chk_one_wait: assert property (s_req_new |=> acc)
    else $error("waitrequest not low in second cycle");
  chk_read_ctl: assert property (avs_read && acc && avs_address == `E3TX_ADDR_CONTROL
    |-> avs_readdata == {16'h0000, ctl_r}) else $error("control readback wrong");
  chk_read_hole: assert property (avs_read && acc && avs_address != `E3TX_ADDR_CONTROL
    && avs_address != `E3TX_ADDR_ERRINS |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_n_one: assert property (s_n_pos ##0 ctl_r[9:8] == `E3TX_N_ONE |=> line_data)
    else $error("N bit not one");
  chk_n_zero: assert property (s_n_pos ##0 ctl_r[9:8] == `E3TX_N_ZERO |=> !line_data)
    else $error("N bit not zero");
  chk_n_hdlc: assert property (s_n_pos ##0 ctl_r[9:8] == `E3TX_N_HDLC
    |=> line_data == $past(hdlc_bit)) else $error("N bit not HDLC bit");
  chk_a_fixed: assert property (s_a_pos ##0 ctl_r[3]
    |=> line_data == $past(ctl_r[2])) else $error("A bit constant wrong");
  chk_fas_gen: assert property (gen && pos < 4'hA && !ei_r[2]
    |=> line_data == fas_word[$past(pos)]) else $error("alignment word wrong");
  chk_pass_thru: assert property (pay_valid && ctl_r[1:0] == 2'b10 && !ei_r[2]
    |=> line_data == $past(pay_data)) else $error("payload not passed");
  chk_alarm_ones: assert property (pay_valid && ctl_r[0] |=> line_data)
    else $error("alarm stream not all ones");
  chk_feac_take: assert property (pay_valid && pay_frame_start
    |-> feac_bit_take == (ctl_r[9:8] == `E3TX_N_FEAC || ctl_r[3:2] == `E3TX_A_FEAC))
    else $error("FEAC take pulse wrong");
  chk_hdlc_take: assert property (s_n_pos
    |-> hdlc_bit_take == (ctl_r[9:8] == `E3TX_N_HDLC)) else $error("HDLC take pulse wrong");
endmodule
bind e3tx_overhead e3tx_checker u_chk (.core_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pay_valid, .pay_data,
  .pay_frame_start, .hdlc_bit, .line_data, .hdlc_bit_take, .feac_bit_take);
`default_nettype wire

// ===== dv/e3tx_line_model.sv
// Line interface model: shifts in every valid line bit, oldest at bit 0.
// Knows no framing; the bench reads the last twelve bits after each frame.
`timescale 1ns/1ps
`default_nettype none
module e3tx_line_model (
  input wire logic core_clk,
  input wire logic line_valid,
  input wire logic line_data,
  output logic [11:0] rx_bits
);
  initial rx_bits = 12'h000;
  always @(posedge core_clk) begin
    if (line_valid)
      rx_bits <= {line_data, rx_bits[11:1]};
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the E3 transmit overhead block.
// Assumes the map header on the include path; frames are twelve bits long.
`timescale 1ns/1ps
`default_nettype none
`include "e3tx_map.vh"
module tb_top;
  localparam logic [9:0] fas_word = 10'h02F;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic pay_valid, pay_data, pay_frame_start, hdlc_bit, feac_bit, ext_in;
  logic line_valid, line_data;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [3:0] avs_byteenable, rx, dis;
  logic [11:0] rx_bits, pay;
  logic [15:0] ctl;
  int err_count, n_compared, cyc;
  e3tx_overhead dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pay_valid(pay_valid), .pay_data(pay_data),
    .pay_frame_start(pay_frame_start), .hdlc_bit(hdlc_bit), .feac_bit(feac_bit),
    .rx_los(rx[0]), .rx_oof(rx[1]), .rx_ais(rx[2]), .rx_lof(rx[3]),
    .rai_los_disable(dis[0]), .rai_oof_disable(dis[1]), .rai_ais_disable(dis[2]),
    .rai_lof_enable(dis[3]), .external_error_insert_input(ext_in),
    .line_valid(line_valid), .line_data(line_data), .hdlc_bit_take(), .feac_bit_take());
  e3tx_line_model u_line (.core_clk(core_clk), .line_valid(line_valid),
    .line_data(line_data), .rx_bits(rx_bits));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Entered just after a rising edge; one wait state is not assumed
  task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [11:0] expf(input logic [11:0] p, input logic [9:0] m);
    logic n;
    logic a;
    n = ctl[9] ? (ctl[8] ? 1'b0 : feac_bit) : (ctl[8] ? hdlc_bit : 1'b1);
    a = ctl[3] ? ctl[2] : (ctl[2] ? feac_bit : |(rx & (dis ^ 4'h7)));
    if (ctl[0])
      expf = 12'hFFF;
    else if (ctl[1])
      expf = p ^ {2'b00, m};
    else
      expf = {n, a, fas_word ^ m};
  endfunction
  task automatic frame(input logic [9:0] m);
    pay = 12'($urandom);
    for (int k = 0; k < 12; k++) begin
      pay_valid <= 1'b1;
      pay_data <= pay[k];
      pay_frame_start <= (k == 0);
      @(posedge core_clk);
    end
    pay_valid <= 1'b0;
    pay_frame_start <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("frame", {20'h0, expf(pay, m)}, {20'h0, rx_bits});
    @(posedge core_clk);
  endtask
  task automatic einj(input logic [15:0] ei, input int how, input int nerr,
    input logic [9:0] m);
    bus(1'b1, `E3TX_ADDR_ERRINS, ei);
    bus(1'b1, `E3TX_ADDR_ERRINS, ei | 16'h0002);
    if (how == 1) begin
      bus(1'b1, `E3TX_ADDR_ERRINS, ei);
      bus(1'b1, `E3TX_ADDR_ERRINS, ei | 16'h0002);
    end
    if (how == 2) begin
      ext_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_in <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    for (int j = 0; j < 6; j++)
      frame(j < nerr ? m : 10'h000);
    bus(1'b1, `E3TX_ADDR_ERRINS, ei);
    $display("error insertion test done");
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    {rst_n, avs_read, avs_write, pay_valid, pay_data, pay_frame_start} = 6'h00;
    {hdlc_bit, feac_bit, ext_in, rx, dis, ctl} = 27'h0;
    {avs_address, avs_writedata, cyc, err_count, n_compared} = 0;
    avs_byteenable = 4'hF;
    void'($urandom(68));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, `E3TX_ADDR_CONTROL, 16'h0000);
    chk("control reset", 32'h0, rdata);
    bus(1'b0, `E3TX_ADDR_ERRINS, 16'h0000);
    chk("error insert reset", 32'h0, rdata);
    bus(1'b1, `E3TX_ADDR_CONTROL, 16'hFFFF);
    bus(1'b0, `E3TX_ADDR_CONTROL, 16'h0000);
    chk("control mask", 32'h030F, rdata);
    bus(1'b0, 10'h070, 16'h0000);
    chk("unmapped", 32'h0, rdata);
    $display("register test done");
    for (int i = 0; i < 48; i++) begin
      ctl = {6'h00, i[1:0], 4'h0, i[3:2], ($urandom % 4 == 0), ($urandom % 3 == 0)};
      {hdlc_bit, feac_bit, rx, dis} <= 10'($urandom);
      bus(1'b1, `E3TX_ADDR_CONTROL, ctl);
      frame(10'h000);
    end
    $display("overhead fill test done");
    ctl = 16'h000C;
    bus(1'b1, `E3TX_ADDR_CONTROL, ctl);
    for (int k = 0; k < 4; k++)
      einj(16'h0004 | 16'(k << 3), 0, k[1] ? 4 : 1, k[0] ? 10'h3FF : 10'h001);
    einj(16'h0004, 1, 1, 10'h001);
    einj(16'h0000, 0, 0, 10'h000);
    einj(16'h000D, 2, 1, 10'h3FF);
    final_report();
  end
endmodule
`default_nettype wire
